/* File: rtl/fdrg_defs.vh */
/*
 * Constants of the serial flash command decoder: opcodes, dummy counts,
 * page and FIFO sizes. Assumes inclusion by the decoder file only.
 */
`ifndef FDRG_DEFS_VH
`define FDRG_DEFS_VH
// Opcodes
`define FDRG_OP_WREN     8'h06
`define FDRG_OP_WREN_VSR 8'h50
`define FDRG_OP_WRDI     8'h04
`define FDRG_OP_RST      8'h99
`define FDRG_OP_RDSR1    8'h05
`define FDRG_OP_RDSR2    8'h35
`define FDRG_OP_RDSR3    8'h15
`define FDRG_OP_WRSR1    8'h01
`define FDRG_OP_WRSR2    8'h31
`define FDRG_OP_WRSR3    8'h11
`define FDRG_OP_PP       8'h02
`define FDRG_OP_PP4      8'h12
`define FDRG_OP_SECPGM   8'h42
`define FDRG_OP_SECERS   8'h44
`define FDRG_OP_DTR_FR   8'h0d
`define FDRG_OP_DTR_WRAP 8'h0e
`define FDRG_OP_DTR_DUAL 8'hbd
`define FDRG_OP_DTR_QUAD 8'hed
`define FDRG_OP_DTR_Q4B  8'hee
// Dummy clocks per DTR read
`define FDRG_DUM_FR      5'd6
`define FDRG_DUM_DUAL    5'd4
`define FDRG_DUM_QUAD    5'd7
`define FDRG_DUM_QPI_DEF 5'd8
// Page wrap mask, FIFO depth
`define FDRG_PAGE_MASK   8'hff
`define FDRG_FIFO_DEPTH  32
`endif

/* File: rtl/fdrg_decoder.v */
/*
 * Serial flash command decoder with DTR reads, write-enable gating and a
 * program-data FIFO. Assumes i_sclk, i_cs_n and i_io come from the pins and
 * are asynchronous; i_sclk must be slower than a quarter of i_clk.
 */
`timescale 1ns/1ps
`include "fdrg_defs.vh"

// ***********************************************************
// Program data FIFO
// ***********************************************************
module fdrg_fifo
#(
   parameter WIDTH = 16,
   parameter DEPTH = 32,
   parameter AW    = 5
)
(
   input  wire             i_clk,
   input  wire             i_srst,
   input  wire             i_in_valid,
   output wire             o_in_ready,
   input  wire [WIDTH-1:0] i_in_data,
   output wire             o_out_valid,
   input  wire             i_out_ready,
   output wire [WIDTH-1:0] o_out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];   // Storage
   reg [AW:0]      wr_ptr;            // Write pointer, wrap bit on top
   reg [AW:0]      rd_ptr;            // Read pointer
   wire            full;
   wire            empty;
   assign full        = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   assign empty       = (wr_ptr == rd_ptr);
   assign o_in_ready  = ~full;
   assign o_out_valid = ~empty;
   assign o_out_data  = mem[rd_ptr[AW-1:0]];
   // Pointer and storage update
   always @(posedge i_clk)
   begin
      if (i_srst)
      begin
         wr_ptr <= {(AW+1){1'b0}};
         rd_ptr <= {(AW+1){1'b0}};
      end
      else
      begin
         if (i_in_valid && !full)
         begin
            mem[wr_ptr[AW-1:0]] <= i_in_data;
            wr_ptr              <= wr_ptr + 1'b1;
         end
         if (i_out_ready && !empty)
            rd_ptr <= rd_ptr + 1'b1;
      end
   end
endmodule // fdrg_fifo

// ***********************************************************
// Command decoder top
// ***********************************************************
module fdrg_decoder
(
   input  wire        i_clk,
   input  wire        i_srst,
   input  wire        i_sclk,                // Link clock pin
   input  wire        i_cs_n,                // Chip select pin
   input  wire [3:0]  i_io,                  // IO3..IO0 input
   output reg  [3:0]  o_io,                  // IO3..IO0 output
   output reg  [3:0]  o_io_oe_n,             // Low while driving
   input  wire        i_four_line_command_mode,
   input  wire        i_addr4,               // 4-byte address mode
   input  wire [7:0]  i_read_param,          // Dummy field high, wrap low
   input  wire [7:0]  i_status1,
   input  wire [7:0]  i_status2,
   input  wire [7:0]  i_status3,
   input  wire        i_op_done,             // Array op finished, pulse
   input  wire [7:0]  i_rd_data,             // Array byte at o_rd_addr
   output reg  [31:0] o_rd_addr,
   output reg         o_write_enable_latch,
   output reg         o_vol_sr_enable,       // Volatile status enable
   output reg         o_exec,                // Accepted op, pulse
   output reg  [7:0]  o_exec_op,
   output reg  [31:0] o_exec_addr,
   output reg         o_sr1_we,
   output reg         o_sr2_we,
   output reg         o_sr3_we,
   output reg  [7:0]  o_sr_data1,
   output reg  [7:0]  o_sr_data2,
   output reg         o_sec_valid,           // Security address legal
   output reg  [1:0]  o_sec_reg,
   output reg  [8:0]  o_sec_byte,
   output reg  [7:0]  o_continuous_mode_byte,
   output reg         o_prog_drop,           // Byte lost to full FIFO
   output wire        o_prog_valid,
   input  wire        i_prog_ready,
   output wire [7:0]  o_prog_data,
   output wire [7:0]  o_prog_col             // Column within page
);
   // ********************************************************
   // States, one-hot
   // ********************************************************
   localparam [6:0] ST_CMD   = 7'h01;
   localparam [6:0] ST_ADDR  = 7'h02;
   localparam [6:0] ST_MODE  = 7'h04;
   localparam [6:0] ST_DUMMY = 7'h08;
   localparam [6:0] ST_RDATA = 7'h10;
   localparam [6:0] ST_WDATA = 7'h20;
   localparam [6:0] ST_IDLE  = 7'h40;

   reg  [2:0]  sclk_s;             // Sync stages plus edge history
   reg  [1:0]  cs_s;               // Chip select sync
   reg  [3:0]  io_s1;              // First sync stage
   reg  [3:0]  io_s2;              // Second sync stage
   reg         cs_q;               // Previous synced chip select
   reg         dtr_arm;            // Falling edges counted
   reg  [6:0]  state;
   reg  [7:0]  op;                 // Latched opcode
   reg  [7:0]  sh_in;              // Input shifter
   reg  [3:0]  bcnt;               // Bits in current byte
   reg  [2:0]  abytes;             // Address bytes left
   reg  [31:0] addr;
   reg  [5:0]  dcnt;               // Dummy edges left
   reg  [7:0]  sh_out;             // Output shifter
   reg  [8:0]  nbytes;             // Data bytes received
   reg  [7:0]  col;                // Page column
   reg         push;
   reg  [15:0] push_data;
   wire        fifo_ready;
   wire [15:0] fifo_out;
   reg  [2:0]  w;                  // Bits per beat
   wire        sck_rise;
   wire        sck_fall;
   wire        cs_on;
   wire        is_dtr;
   wire        edge_ev;
   wire [7:0]  sh_next;
   wire [4:0]  qpi_dum;
   wire [5:0]  wrap_mask;

   // Four-line dummy count, zero field falls back to default
   // upper parameter field
   assign qpi_dum   = (i_read_param[7:4] == 4'h0) ? `FDRG_DUM_QPI_DEF
                                                  : {1'b0, i_read_param[7:4]};
   assign wrap_mask = 6'h3f >> (2'd3 - i_read_param[1:0]);

   assign sck_rise = sclk_s[1] & ~sclk_s[2];
   assign sck_fall = ~sclk_s[1] & sclk_s[2];
   assign cs_on    = ~cs_s[1];
   assign is_dtr   = (op == `FDRG_OP_DTR_FR) || (op == `FDRG_OP_DTR_WRAP) ||
                     (op == `FDRG_OP_DTR_DUAL) || (op == `FDRG_OP_DTR_QUAD) ||
                     (op == `FDRG_OP_DTR_Q4B);
   // Falling edges count only after the first rise past the opcode;
   // the opcode's own last falling edge carries no address bit
   assign edge_ev  = cs_on & (sck_rise | (sck_fall & is_dtr & dtr_arm));

   // MSB-first shift, IO1 or IO3 holds upper bit
   assign sh_next = (w == 3'd4) ? {sh_in[3:0], io_s2[3:0]} :
                    (w == 3'd2) ? {sh_in[5:0], io_s2[1:0]} :
                                  {sh_in[6:0], io_s2[0]};

   // Instructions that require a prior write enable
   function gated;
      input [7:0] c;
      begin
         case (c)
            8'h02, 8'h12, 8'h32, 8'h34, 8'h42, 8'h44, 8'h20, 8'h21, 8'h52, 8'h5c,
            8'hd8, 8'hdc, 8'h60, 8'hc7, 8'hc5, 8'h2c, 8'ha6, 8'he3, 8'he4, 8'h36,
            8'h39, 8'ha8, 8'ha9, 8'h7e, 8'h98, 8'h28, 8'h29: gated = 1'b1;
            default: gated = 1'b0;
         endcase
      end
   endfunction

   // Instructions that carry an address
   function has_addr;
      input [7:0] c;
      begin
         case (c)
            8'h02, 8'h12, 8'h42, 8'h44, 8'h20, 8'h21, 8'h52, 8'h5c, 8'hd8, 8'hdc,
            8'h36, 8'h39, 8'he3, 8'h0d, 8'h0e, 8'hbd, 8'hed, 8'hee: has_addr = 1'b1;
            default: has_addr = 1'b0;
         endcase
      end
   endfunction

   // ********************************************************
   // Beat width per phase
   // ********************************************************
   always @*
   begin
      w = i_four_line_command_mode ? 3'd4 : 3'd1;
      if (state != ST_CMD)
      begin
         if (op == `FDRG_OP_DTR_DUAL)
            w = 3'd2;
         else if ((op == `FDRG_OP_DTR_QUAD) || (op == `FDRG_OP_DTR_Q4B))
            w = 3'd4;
      end
   end

   // ********************************************************
   // Pin synchronisers
   // ********************************************************
   always @(posedge i_clk)
   begin
      if (i_srst)
      begin
         sclk_s <= 3'h0;
         cs_s   <= 2'h3;
         io_s1  <= 4'h0;
         io_s2  <= 4'h0;
      end
      else
      begin
         sclk_s <= {sclk_s[1:0], i_sclk};
         cs_s   <= {cs_s[0], i_cs_n};
         io_s1  <= i_io;
         io_s2  <= io_s1;
      end
   end

   // ********************************************************
   // Frame engine
   // ********************************************************
   always @(posedge i_clk)
   begin
      push     <= 1'b0;
      o_exec   <= 1'b0;
      o_sr1_we <= 1'b0;
      o_sr2_we <= 1'b0;
      o_sr3_we <= 1'b0;
      o_prog_drop <= 1'b0;
      if (i_srst)
      begin
         cs_q      <= 1'b1;
         dtr_arm   <= 1'b0;
         state     <= ST_CMD;
         op        <= 8'h00;
         sh_in     <= 8'h00;
         bcnt      <= 4'h0;
         abytes    <= 3'h0;
         addr      <= 32'h0;
         dcnt      <= 6'h0;
         sh_out    <= 8'h00;
         nbytes    <= 9'h0;
         col       <= 8'h00;
         push_data <= 16'h0;
         o_io      <= 4'h0;
         o_io_oe_n <= 4'hf;
         o_rd_addr <= 32'h0;
         o_write_enable_latch   <= 1'b0;
         o_vol_sr_enable        <= 1'b0;
         o_exec_op              <= 8'h00;
         o_exec_addr            <= 32'h0;
         o_sr_data1             <= 8'h00;
         o_sr_data2             <= 8'h00;
         o_sec_valid            <= 1'b0;
         o_sec_reg              <= 2'h0;
         o_sec_byte             <= 9'h0;
         o_continuous_mode_byte <= 8'h00;
      end
      else
      begin
         cs_q <= cs_s[1];
         // Arm double-rate sampling on the first rise after the opcode
         if (!cs_on || (state == ST_CMD))
            dtr_arm <= 1'b0;
         else if (sck_rise)
            dtr_arm <= 1'b1;
         // array op completion clears the latch
         if (i_op_done)
            o_write_enable_latch <= 1'b0;
         if (!cs_on)
         begin
            state     <= ST_CMD;
            bcnt      <= 4'h0;
            nbytes    <= 9'h0;
            o_io_oe_n <= 4'hf;
         end
         // Chip select rise ends the frame and commits the op
         if (cs_s[1] && !cs_q && (state != ST_CMD))
         begin
            case (op)
               // enables exclusive; set wins over completion clear
               `FDRG_OP_WREN:
                  if (!o_vol_sr_enable)
                     o_write_enable_latch <= 1'b1;
               `FDRG_OP_WREN_VSR:
                  if (!o_write_enable_latch)
                     o_vol_sr_enable <= 1'b1;
               `FDRG_OP_WRDI, `FDRG_OP_RST:
               begin
                  o_write_enable_latch <= 1'b0;
                  o_vol_sr_enable      <= 1'b0;
               end
               `FDRG_OP_WRSR1, `FDRG_OP_WRSR2, `FDRG_OP_WRSR3:
                  if ((o_write_enable_latch || o_vol_sr_enable) && (bcnt == 4'h0) &&
                      (nbytes != 9'h0))
                  begin
                     o_sr1_we <= (op == `FDRG_OP_WRSR1);
                     o_sr2_we <= (op == `FDRG_OP_WRSR2) ||
                                 ((op == `FDRG_OP_WRSR1) && (nbytes == 9'h2));
                     o_sr3_we <= (op == `FDRG_OP_WRSR3);
                     o_vol_sr_enable <= 1'b0;
                  end
               default:
                  // gated op runs only with the latch
                  if (gated(op) && o_write_enable_latch && (state != ST_ADDR))
                  begin
                     o_exec      <= 1'b1;
                     o_exec_op   <= op;
                     o_exec_addr <= addr;
                  end
            endcase
         end
         if (edge_ev)
         begin
            sh_in <= sh_next;
            bcnt  <= bcnt + {1'b0, w};
            case (state)
               ST_CMD:
                  if (bcnt + {1'b0, w} == 4'h8)
                  begin
                     bcnt <= 4'h0;
                     op   <= sh_next;
                     addr <= 32'h0;
                     // extra address byte in 4-byte forms
                     abytes <= (i_addr4 || (sh_next == `FDRG_OP_DTR_Q4B) ||
                                (sh_next == 8'h12) || (sh_next == 8'h21) ||
                                (sh_next == 8'h5c) || (sh_next == 8'hdc)) ? 3'd4 : 3'd3;
                     if (has_addr(sh_next))
                        state <= ST_ADDR;
                     else if ((sh_next == `FDRG_OP_RDSR1) || (sh_next == `FDRG_OP_RDSR2) ||
                              (sh_next == `FDRG_OP_RDSR3))
                     begin
                        state  <= ST_RDATA;
                        sh_out <= (sh_next == `FDRG_OP_RDSR1) ? i_status1 :
                                  (sh_next == `FDRG_OP_RDSR2) ? i_status2 : i_status3;
                     end
                     else
                        state <= ST_WDATA;
                  end
               ST_ADDR:
                  if (bcnt + {1'b0, w} == 4'h8)
                  begin
                     bcnt   <= 4'h0;
                     addr   <= {addr[23:0], sh_next};
                     abytes <= abytes - 3'd1;
                     if (abytes == 3'd1)
                     begin
                        col <= sh_next;
                        o_sec_valid <= (addr[15:8] == 8'h00) && (addr[3:1] == 3'h0) &&
                                       (addr[7:4] != 4'h0) && (addr[7:4] < 4'h4);
                        o_sec_reg   <= addr[5:4];
                        o_sec_byte  <= {addr[0], sh_next};
                        if ((op == `FDRG_OP_DTR_DUAL) || (op == `FDRG_OP_DTR_QUAD) ||
                            (op == `FDRG_OP_DTR_Q4B))
                           state <= ST_MODE;
                        else if (op == `FDRG_OP_DTR_FR || op == `FDRG_OP_DTR_WRAP)
                        begin
                           state <= ST_DUMMY;
                           dcnt  <= {(i_four_line_command_mode ? qpi_dum : `FDRG_DUM_FR),
                                     1'b0};
                        end
                        else
                           state <= ST_WDATA;
                     end
                  end
               ST_MODE:
                  if (bcnt + {1'b0, w} == 4'h8)
                  begin
                     bcnt  <= 4'h0;
                     o_continuous_mode_byte <= sh_next;
                     state <= ST_DUMMY;
                     dcnt  <= {((op == `FDRG_OP_DTR_DUAL) ? `FDRG_DUM_DUAL
                                                          : `FDRG_DUM_QUAD), 1'b0};
                  end
               ST_DUMMY:
               begin
                  bcnt <= 4'h0;
                  dcnt <= dcnt - 6'd1;
                  if (dcnt == 6'd1)
                  begin
                     state     <= ST_RDATA;
                     sh_out    <= i_rd_data;
                     o_rd_addr <= addr + 32'd1;
                  end
                  else
                     o_rd_addr <= addr;
               end
               ST_RDATA:
                  if (bcnt + {1'b0, w} == 4'h8)
                  begin
                     bcnt <= 4'h0;
                     if (is_dtr)
                     begin
                        sh_out <= i_rd_data;
                        // wrapped read stays in its window in four-line mode only
                        if (op == `FDRG_OP_DTR_WRAP && i_four_line_command_mode)
                           o_rd_addr <= {o_rd_addr[31:6],
                                         (o_rd_addr[5:0] & ~wrap_mask) |
                                         ((o_rd_addr[5:0] + 6'd1) & wrap_mask)};
                        else
                           o_rd_addr <= o_rd_addr + 32'd1;
                     end
                     else
                        sh_out <= (op == `FDRG_OP_RDSR1) ? i_status1 :
                                  (op == `FDRG_OP_RDSR2) ? i_status2 : i_status3;
                  end
                  else
                     sh_out <= (w == 3'd4) ? {sh_out[3:0], 4'h0} :
                               (w == 3'd2) ? {sh_out[5:0], 2'h0} : {sh_out[6:0], 1'b0};
               ST_WDATA:
                  if (bcnt + {1'b0, w} == 4'h8)
                  begin
                     bcnt <= 4'h0;
                     if (nbytes != 9'h1ff)
                        nbytes <= nbytes + 9'd1;
                     if (nbytes == 9'h0)
                        o_sr_data1 <= sh_next;
                     if ((nbytes == 9'h0 && op != `FDRG_OP_WRSR1) || nbytes == 9'h1)
                        o_sr_data2 <= sh_next;
                     // page data, column wraps at page end
                     if (((op == `FDRG_OP_PP) || (op == `FDRG_OP_PP4) ||
                          (op == `FDRG_OP_SECPGM)) && o_write_enable_latch)
                     begin
                        col <= (col + 8'd1) & `FDRG_PAGE_MASK;
                        if (fifo_ready)
                        begin
                           push      <= 1'b1;
                           push_data <= {col, sh_next};
                        end
                        else
                           o_prog_drop <= 1'b1;
                     end
                  end
               default:
                  state <= ST_IDLE;
            endcase
         end
         // drive pins in data phase, upper bits first
         if (cs_on && state == ST_RDATA)
         begin
            if (w == 3'd4)
            begin
               o_io      <= sh_out[7:4];
               o_io_oe_n <= 4'h0;
            end
            else if (w == 3'd2)
            begin
               o_io      <= {2'h0, sh_out[7:6]};
               o_io_oe_n <= 4'hc;
            end
            else
            begin
               o_io      <= {2'h0, sh_out[7], 1'b0};
               o_io_oe_n <= 4'hd;
            end
         end
      end
   end

   // ********************************************************
   // Program data buffer
   // ********************************************************
   fdrg_fifo
   #(
      .WIDTH (16),
      .DEPTH (`FDRG_FIFO_DEPTH),
      .AW    (5)
   )
   u_fifo
   (
      .i_clk       (i_clk),
      .i_srst      (i_srst),
      .i_in_valid  (push),
      .o_in_ready  (fifo_ready),
      .i_in_data   (push_data),
      .o_out_valid (o_prog_valid),
      .i_out_ready (i_prog_ready),
      .o_out_data  (fifo_out)
   );
   assign o_prog_data = fifo_out[7:0];
   assign o_prog_col  = fifo_out[15:8];
endmodule // fdrg_decoder

/* File: testbench/fdrg_chk.sv */
/* Port assertions for the flash command decoder.
   Assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/1ps
module fdrg_chk
(
   input wire       i_clk,
   input wire       i_srst,
   input wire       i_cs_n,
   input wire       i_op_done,
   input wire [3:0] o_io_oe_n,
   input wire       o_write_enable_latch,
   input wire       o_vol_sr_enable,
   input wire       o_exec,
   input wire [7:0] o_exec_op,
   input wire       o_sr1_we,
   input wire       o_sec_valid,
   input wire [1:0] o_sec_reg
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);
   chk_reset_idle: assert property ($fell(i_srst) |-> o_io_oe_n == 4'hf && !o_write_enable_latch)
      else $error("outputs not idle after reset");
   chk_exec_pulse: assert property (o_exec |=> !o_exec)
      else $error("exec longer than one cycle");
   chk_oe_release: assert property (i_cs_n [*6] |-> o_io_oe_n == 4'hf)
      else $error("pins driven while deselected");
   chk_exec_frame: assert property (o_exec |-> $past(i_cs_n, 2))
      else $error("exec without chip select rise");
   chk_gated_op: assert property (o_exec && (o_exec_op == 8'h02 || o_exec_op == 8'h44)
      |-> $past(o_write_enable_latch))
      else $error("gated op without enable");
   chk_status_gate: assert property (o_sr1_we |->
      $past(o_write_enable_latch) || $past(o_vol_sr_enable))
      else $error("status write without enable");
   chk_enable_excl: assert property (!(o_write_enable_latch && o_vol_sr_enable))
      else $error("both enables set");
   chk_done_clear: assert property (i_op_done |=> !o_write_enable_latch
      || $rose(o_write_enable_latch))
      else $error("latch kept after completion");
   chk_sec_reg: assert property (o_sec_valid |-> o_sec_reg != 2'd0)
      else $error("security register zero");
   cover property (o_exec && o_exec_op == 8'h02);
   cover property (o_sr1_we);
   cover property (o_sec_valid);
endmodule // fdrg_chk

bind fdrg_decoder fdrg_chk u_chk (.i_clk(i_clk), .i_srst(i_srst), .i_cs_n(i_cs_n),
   .i_op_done(i_op_done), .o_io_oe_n(o_io_oe_n), .o_write_enable_latch(o_write_enable_latch),
   .o_vol_sr_enable(o_vol_sr_enable), .o_exec(o_exec), .o_exec_op(o_exec_op),
   .o_sr1_we(o_sr1_we), .o_sec_valid(o_sec_valid), .o_sec_reg(o_sec_reg));

/* File: testbench/fdrg_host.sv */
/* Behavioural single-line host, mode 0, 125 ns link clock, plain and double rate.
   Assumes the bench resolves the pins by the decoder's output enables. */
`timescale 1ns/1ps
module fdrg_host
(
   output reg       o_sclk,
   output reg       o_cs_n,
   output reg [3:0] o_io,
   input  wire [3:0] i_io
);
   // Idle: clock low, deselected, spare lines released high
   initial begin o_sclk = 0; o_cs_n = 1; o_io = 4'hf; end
   task start; begin o_cs_n = 0; #62.5; end endtask
   task tx(input [7:0] b);
      integer k;
      begin
         for (k = 7; k >= 0; k = k - 1) begin o_io[0] = b[k]; #62.5 o_sclk = 1; #62.5 o_sclk = 0; end
      end
   endtask
   task rx(output [7:0] b);
      integer k;
      begin
         for (k = 7; k >= 0; k = k - 1) begin #62.5 b[k] = i_io[1]; o_sclk = 1; #62.5 o_sclk = 0; end
      end
   endtask
   // double rate: data moves mid-bit, both clock edges sample
   task dtx(input [7:0] b);
      integer k;
      begin
         for (k = 7; k >= 0; k = k - 1) begin #31.25 o_io[0] = b[k]; #31.25 o_sclk = ~o_sclk; end
      end
   endtask
   // Dummy edges, no data
   task dclk(input integer n); begin repeat (n) #62.5 o_sclk = ~o_sclk; end endtask
   // double rate read, sampled just before each edge
   task drx(output [7:0] b);
      integer k;
      begin
         for (k = 7; k >= 0; k = k - 1) begin #62.5 b[k] = i_io[1]; o_sclk = ~o_sclk; end
      end
   endtask
   // Deselect and scramble the data line so stale bits are not trusted
   task stop; begin #62.5 o_cs_n = 1; o_io[0] = ~o_io[0]; #600; end endtask
endmodule // fdrg_host

/* File: testbench/tb.sv */
/* Self-checking bench for the flash command decoder.
   Assumes the host model drives the link pins. */
`timescale 1ns/1ps
module tb;
   reg clk = 0, srst = 1, op_done = 0, prog_ready = 0, four_line_command_mode = 0, a4 = 0;
   reg [7:0] st1 = 0, lfsr = 8'h3d, rb, b1, b2, cl;
   reg [15:0] q[$];
   integer n_mismatch = 0, n_checks = 0, n_ex = 0, n_sr1 = 0, n_sr2 = 0;
   wire sclk, cs_n, lat, vol, ex, w1, w2, sv, pv;
   wire [3:0] hio, dio, oe_n, pin;
   wire [7:0] eop, d1, d2, pd, pc, mrd;
   wire [1:0] sreg;
   wire [8:0] sbyte;
   wire [31:0] eaddr, ra;
   assign pin = (~oe_n & dio) | (oe_n & hio);
   // Array model: byte at address A is A[7:0] ^ a5
   assign mrd = ra[7:0] ^ 8'ha5;
   always #4 clk = ~clk;
   fdrg_host u_fdrg_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_io(hio), .i_io(pin));
   fdrg_decoder u_fdrg_decoder (.i_clk(clk), .i_srst(srst), .i_sclk(sclk), .i_cs_n(cs_n),
      .i_io(pin), .o_io(dio), .o_io_oe_n(oe_n), .i_four_line_command_mode(four_line_command_mode), .i_addr4(a4),
      .i_read_param(lfsr), .i_status1(st1), .i_status2(~st1), .i_status3(lfsr), .i_op_done(op_done),
      .i_rd_data(mrd), .o_rd_addr(ra), .o_write_enable_latch(lat), .o_vol_sr_enable(vol), .o_exec(ex),
      .o_exec_op(eop), .o_exec_addr(eaddr), .o_sr1_we(w1), .o_sr2_we(w2), .o_sr3_we(),
      .o_sr_data1(d1), .o_sr_data2(d2), .o_sec_valid(sv), .o_sec_reg(sreg), .o_sec_byte(sbyte),
      .o_continuous_mode_byte(), .o_prog_drop(), .o_prog_valid(pv), .i_prog_ready(prog_ready),
      .o_prog_data(pd), .o_prog_col(pc));
   function [7:0] nxt(input [7:0] s); nxt = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]}; endfunction
   task chk(input [8*6-1:0] nm, input [31:0] e, input [31:0] g);
      begin
         n_checks = n_checks + 1;
         if (e !== g) begin n_mismatch = n_mismatch + 1; $display("[ERR] %0s exp %h got %h", nm, e, g); end
      end
   endtask
   task stop_test;
      begin
         if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
         else $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   task cmd(input [7:0] c); begin u_fdrg_host.start; u_fdrg_host.tx(c); u_fdrg_host.stop; end endtask
   task adr(input [23:0] a); begin u_fdrg_host.tx(a[23:16]); u_fdrg_host.tx(a[15:8]); u_fdrg_host.tx(a[7:0]); end endtask
   // Random drain pace, exec count and program stream model
   always @(posedge clk) begin
      lfsr <= nxt(lfsr);
      prog_ready <= lfsr[0];
      if (ex) n_ex = n_ex + 1;
      if (w1) n_sr1 = n_sr1 + 1;
      if (w2) n_sr2 = n_sr2 + 1;
      if (pv && prog_ready) chk("prog", q.pop_front(), {pc, pd});
   end
   initial begin #400000; n_mismatch = n_mismatch + 1; stop_test; end
   initial begin
      repeat (3) @(posedge clk);
      srst <= 0;
      repeat (6) @(posedge clk);
      chk("oe", 4'hf, oe_n); chk("lat", 0, lat);
      u_fdrg_host.start; u_fdrg_host.tx(8'h02); adr(24'h000100); u_fdrg_host.tx(lfsr); u_fdrg_host.stop;
      chk("nex", 0, n_ex);
      cmd(8'h06); chk("lat", 1, lat);
      cmd(8'h50); chk("vol", 0, vol);
      u_fdrg_host.start; u_fdrg_host.tx(8'h02); adr(24'h0123fe);
      cl = 8'hfe;
      repeat (3) begin rb = lfsr; q.push_back({cl, rb}); cl = cl + 8'd1; u_fdrg_host.tx(rb); end
      u_fdrg_host.stop; #2000;
      chk("nex", 1, n_ex); chk("op", 8'h02, eop); chk("addr", 32'h0123fe, eaddr); chk("left", 0, q.size());
      @(posedge clk) op_done <= 1;
      @(posedge clk) op_done <= 0;
      repeat (2) @(posedge clk);
      chk("lat", 0, lat);
      cmd(8'h50); chk("vol", 1, vol); cmd(8'h06); chk("lat", 0, lat);
      b1 = lfsr; b2 = nxt(b1);
      u_fdrg_host.start; u_fdrg_host.tx(8'h01); u_fdrg_host.tx(b1); u_fdrg_host.tx(b2); u_fdrg_host.stop;
      chk("sr1", b1, d1); chk("sr2", b2, d2); chk("nsr2", 1, n_sr2);
      chk("nsr1", 1, n_sr1);
      cmd(8'h06); cmd(8'h04); chk("lat", 0, lat);
      cmd(8'h06); u_fdrg_host.start; u_fdrg_host.tx(8'h44); adr(24'h0021a5); u_fdrg_host.stop;
      chk("sv", 1, sv); chk("sreg", 2, sreg); chk("sbyte", 9'h1a5, sbyte); chk("nex", 2, n_ex);
      @(posedge clk) a4 <= 1;
      cmd(8'h06); u_fdrg_host.start; u_fdrg_host.tx(8'h20); u_fdrg_host.tx(8'h89);
      adr(24'habcdef); u_fdrg_host.stop;
      @(posedge clk) a4 <= 0;
      chk("nex", 3, n_ex); chk("addr4", 32'h89abcdef, eaddr);
      @(posedge clk) st1 <= lfsr;
      u_fdrg_host.start; u_fdrg_host.tx(8'h05);
      repeat (2) begin u_fdrg_host.rx(rb); chk("stat", st1, rb); end
      u_fdrg_host.stop;
      u_fdrg_host.start; u_fdrg_host.tx(8'h0d); u_fdrg_host.dtx(8'h12);
      u_fdrg_host.dtx(8'h34); u_fdrg_host.dtx(8'h56); u_fdrg_host.dclk(12);
      u_fdrg_host.drx(rb); chk("dtr0", 8'h56 ^ 8'ha5, rb);
      u_fdrg_host.drx(rb); chk("dtr1", 8'h57 ^ 8'ha5, rb);
      u_fdrg_host.stop;
      stop_test;
   end
endmodule // tb
